// File: rtl/ata_cmd_cfg.svh
// constants for the storage command decoder: map, codes, words, timing
`ifndef ATA_CMD_CFG_SVH
`define ATA_CMD_CFG_SVH
// register byte offsets
`define ADR_TF0       8'h00
`define ADR_TF1       8'h04
`define ADR_CMD       8'h08
`define ADR_STAT      8'h0C
`define ADR_DATA      8'h10
`define ADR_LBA_LO    8'h14
`define ADR_LBA_HI    8'h18
`define ADR_CTRL      8'h1C
// command codes
`define CMD_CHK_PWR   8'hE5
`define CMD_OVERLAY   8'hB1
`define CMD_DIAG      8'h90
`define CMD_FLUSH     8'hE7
`define CMD_FLUSH_EXT 8'hEA
`define CMD_IDENT     8'hEC
`define CMD_NATMAX    8'hF8
`define CMD_NATMAX48  8'h27
`define CMD_WR_DMA_FUA 8'h3D
`define CMD_WR_MUL_FUA 8'hCE
`define CMD_SMART     8'hB0
`define CMD_SET_MAX   8'hF9
`define CMD_SET_MAX48 8'h37
// overlay subcommands in the feature field
`define SUB_RESTORE   8'hC0
`define SUB_FREEZE    8'hC1
`define SUB_IDENT     8'hC2
`define SUB_SET       8'hC3
// power query results
`define PWR_RES_STBY  8'h00
`define PWR_RES_IDLE  8'h80
`define PWR_RES_ACT   8'hFF
// error register codes and unit select position
`define ERR_ABORT     8'h04
`define DIAG_PASS     8'h01
`define UNIT_BIT      4
// status field positions
`define ST_BUSY       0
`define ST_ERR        1
`define ST_DRQ        2
`define ST_FROZEN     3
// identify and overlay words
`define ID_GENCFG     16'h0040
`define DCO_REV       16'h0002
`define DCO_MDMA      16'h0007
`define DCO_UDMA      16'h007F
`define DCO_FEAT      16'h0089
`define DCO_SIG       8'hA5
`define FEAT_FACTORY  16'h0189
`define FEAT_SMART    0
`define FEAT_SEC      3
`define FEAT_HPA      7
// timing
`define CLK_NS        10
`define FLUSH_NS      1000
`define DIAG_NS       500
`define FLUSH_CYC     ((`FLUSH_NS + `CLK_NS - 1) / `CLK_NS)
`define DIAG_CYC      ((`DIAG_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: rtl/ata_cmd_pkg.sv
// types shared by the storage command decoder
`default_nettype none
package ata_cmd_pkg;
  typedef enum {ST_IDLE, ST_EXEC, ST_DOUT, ST_DIN} cmd_state_e;
  typedef enum {PWR_STANDBY, PWR_IDLE, PWR_ACTIVE} pwr_mode_e;
  typedef enum {ACT_DONE, ACT_ABORT, ACT_FLUSH, ACT_DIAG, ACT_ID_DEV, ACT_ID_DCO,
                ACT_DCO_SET, ACT_RESTORE, ACT_FREEZE, ACT_NATMAX, ACT_WRITE,
                ACT_STBY, ACT_IDLE, ACT_CHK_PWR, ACT_READ} action_e;
  typedef struct packed {
    logic [7:0]  feature;
    logic [7:0]  count;
    logic [7:0]  sector;
    logic [7:0]  devhead;
    logic [15:0] track;
  } taskfile_s;
  typedef struct packed {
    logic [2:0]  mdma;
    logic [6:0]  udma;
    logic [15:0] feat;
    logic [47:0] max_lba;
  } caps_s;
endpackage
`default_nettype wire

// File: rtl/ident_word_gen.sv
// word source for identify device and overlay identify data
`default_nettype none
`include "ata_cmd_cfg.svh"
module ident_word_gen
  import ata_cmd_pkg::*;
(
  input  wire logic [7:0]  idx_i,      // word index 0..255
  input  wire logic        overlay_i,  // high: overlay structure
  input  wire caps_s       cur_i,      // capabilities now reported
  input  wire logic [47:0] fact_max_i, // factory max lba
  output logic      [15:0] word_o      // selected word
);
  logic [7:0]  cksum;
  logic [7:0]  bsum;
  logic [47:0] max28;

  //////////////////////////////////////////////////////////////////////
  // overlay checksum over the non-zero bytes of the structure
  always_comb begin
    bsum = 8'(`DCO_REV + `DCO_MDMA + `DCO_UDMA + `DCO_FEAT + `DCO_SIG);
    for (int b = 0; b < 6; b++) begin
      bsum = bsum + fact_max_i[8*b +: 8];
    end
    cksum = 8'h00 - bsum;
  end

  // 28-bit view of the max address saturates rather than wraps
  assign max28 = (cur_i.max_lba > 48'h0000_0FFF_FFFF) ? 48'h0000_0FFF_FFFF : cur_i.max_lba;

  //////////////////////////////////////////////////////////////////////
  // overlay words show the full selectable set, identify the reduced one
  always_comb begin
    word_o = 16'h0000;
    if (overlay_i) begin
      unique case (idx_i)
        8'h00: word_o = `DCO_REV;
        8'h01: word_o = `DCO_MDMA;
        8'h02: word_o = `DCO_UDMA;
        8'h03: word_o = fact_max_i[15:0];
        8'h04: word_o = fact_max_i[31:16];
        8'h05: word_o = fact_max_i[47:32];
        8'h07: word_o = `DCO_FEAT;
        8'hFF: word_o = {cksum, `DCO_SIG};
        default: word_o = 16'h0000;
      endcase
    end else begin
      unique case (idx_i)
        8'h00: word_o = `ID_GENCFG;
        8'h3C: word_o = max28[15:0];
        8'h3D: word_o = max28[31:16];
        8'h3F: word_o = {13'h0000, cur_i.mdma};
        8'h52: word_o = {5'h00, cur_i.feat[`FEAT_HPA], 6'h00,
                         cur_i.feat[`FEAT_SEC], 2'h0, cur_i.feat[`FEAT_SMART]};
        8'h58: word_o = {9'h000, cur_i.udma};
        8'h64: word_o = cur_i.max_lba[15:0];
        8'h65: word_o = cur_i.max_lba[31:16];
        8'h66: word_o = cur_i.max_lba[47:32];
        default: word_o = 16'h0000;
      endcase
    end
  end
endmodule // ident_word_gen
`default_nettype wire

// File: rtl/ata_command_decoder.sv
// storage command decoder with overlay configuration, wishbone register slave
// Summary of operation
// - power query returns count 00h standby, 80h idle, FFh active.
// - command B1h dispatches on feature C0h..C3h to overlay subcommands.
// - overlay restore returns capabilities and identify data to factory.
// - after freeze lock all overlay subcommands abort until power-on reset.
// - soft reset keeps frozen state; power-on reset gives factory settings.
// - overlay identify returns 512 bytes listing changeable capabilities.
// - after reducing set, identify shows reduced; overlay identify shows full.
// - overlay set never alters features not marked changeable.
// - overlay word 0 holds revision 0002h.
// - overlay word 7 reads 0089h: monitoring, security, protected area.
// - overlay word 1 reads 0007h, word 2 reads 007Fh.
// - overlay set bits not in overlay identify data are ignored.
// - overlay set max address changes both native max reads.
// - device behaves consistently with altered identify data.
// - flush writes cached data, busy held until written.
// - identify returns 512 bytes, word 0 reads 0040h.
// - F8h and 27h read native max; only unit select matters.
// - 3Dh and CEh are forced-unit-access writes.
// - unit select is device/head bit 4, head bits 3..0.
// - fields marked don't-care are ignored by each command.
// - 90h runs diagnostics, result code in error register.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`default_nettype none
`include "ata_cmd_cfg.svh"
module ata_command_decoder
  import ata_cmd_pkg::*;
#(
  parameter logic        UNIT_NUM    = 1'b0,                 // unit this drive answers
  parameter logic [47:0] MAX_LBA_FAC = 48'h0000_00EF_FFFF    // factory max lba
) (
  input  wire logic        clk_i,  // core clock, 100 MHz
  input  wire logic        rst_i,  // power-on reset, sync, high
  input  wire logic        cyc_i,  // wishbone cycle
  input  wire logic        stb_i,  // wishbone strobe
  input  wire logic        we_i,   // wishbone write
  input  wire logic [7:0]  adr_i,  // byte address
  input  wire logic [3:0]  sel_i,  // byte lanes
  input  wire logic [31:0] dat_i,  // write data
  output logic      [31:0] dat_o,  // read data
  output logic             ack_o,  // wishbone ack
  output logic             busy_o  // busy flag
);
  localparam int FL_BOUND = `FLUSH_CYC + 2;
  localparam int DG_BOUND = `DIAG_CYC + 2;
  localparam logic [15:0] CHG_FEAT = `DCO_FEAT;
  localparam logic [7:0]  FLUSH_LD = 8'(`FLUSH_CYC - 1);
  localparam logic [7:0]  DIAG_LD  = 8'(`DIAG_CYC - 1);

  taskfile_s   tf_ff;
  caps_s       caps_ff;
  cmd_state_e  state_ff, nxt_state;
  pwr_mode_e   pwr_ff;
  action_e     act;
  logic        ack_ff, busy_ff, err_ff, frozen_ff, dirty_ff, dco_sel_ff;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [7:0]  errreg_ff, result_ff, cnt_ff, idx_ff;
  logic [47:0] natmax_ff;
  logic [2:0]  set_mdma_ff;
  logic [6:0]  set_udma_ff;
  logic [15:0] set_feat_ff, id_word;
  logic [47:0] set_max_ff;
  logic        wb_req, wr, rd, cmd_go, start, soft_rst, data_rd, data_wr, apply;
  logic [7:0]  code;

  //////////////////////////////////////////////////////////////////////
  // bus strobes: one request per ack, every address answered
  assign wb_req   = cyc_i & stb_i & ~ack_ff;
  assign wr       = wb_req & we_i;
  assign rd       = wb_req & ~we_i;
  assign code     = dat_i[7:0];
  assign cmd_go   = wr && adr_i == `ADR_CMD && sel_i[0] && state_ff == ST_IDLE;
  // a command for the other unit is dropped without any effect
  assign start    = cmd_go && tf_ff.devhead[`UNIT_BIT] == UNIT_NUM;
  assign soft_rst = wr && adr_i == `ADR_CTRL && sel_i[0] && dat_i[0];
  assign data_rd  = rd && adr_i == `ADR_DATA && state_ff == ST_DOUT;
  assign data_wr  = wr && adr_i == `ADR_DATA && state_ff == ST_DIN;
  assign apply    = data_wr && idx_ff == 8'hFF && !soft_rst;

  //////////////////////////////////////////////////////////////////////
  // task file, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tf_ff <= '0;
    end else if (wr && adr_i == `ADR_TF0) begin
      if (sel_i[0]) tf_ff.feature <= dat_i[7:0];
      if (sel_i[1]) tf_ff.count   <= dat_i[15:8];
      if (sel_i[2]) tf_ff.sector  <= dat_i[23:16];
      if (sel_i[3]) tf_ff.devhead <= dat_i[31:24];
    end else if (wr && adr_i == `ADR_TF1) begin
      if (sel_i[0]) tf_ff.track[7:0]  <= dat_i[7:0];
      if (sel_i[1]) tf_ff.track[15:8] <= dat_i[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // decode: each command looks only at the fields it uses
  always_comb begin
    act = ACT_ABORT;
    unique casez (code)
      `CMD_CHK_PWR:                act = ACT_CHK_PWR;
      `CMD_OVERLAY: begin
        if (tf_ff.feature inside {`SUB_RESTORE, `SUB_FREEZE, `SUB_IDENT, `SUB_SET}
            && frozen_ff) begin
          act = ACT_ABORT;
        end else begin
          unique case (tf_ff.feature)
            `SUB_RESTORE: act = ACT_RESTORE;
            `SUB_FREEZE:  act = ACT_FREEZE;
            `SUB_IDENT:   act = ACT_ID_DCO;
            `SUB_SET:     act = ACT_DCO_SET;
            default:      act = ACT_ABORT;
          endcase
        end
      end
      `CMD_DIAG:                   act = ACT_DIAG;
      `CMD_FLUSH, `CMD_FLUSH_EXT:  act = ACT_FLUSH;
      `CMD_IDENT:                  act = ACT_ID_DEV;
      `CMD_NATMAX, `CMD_NATMAX48:  act = ACT_NATMAX;
      `CMD_WR_DMA_FUA, `CMD_WR_MUL_FUA: act = ACT_DONE;
      8'hE0, 8'hE2, 8'hE6:         act = ACT_STBY;
      8'hE1, 8'hE3:                act = ACT_IDLE;
      8'h91, 8'hE4, 8'hE8, 8'h10, 8'hEF, 8'hC6, 8'h7?: act = ACT_DONE;
      8'hC8, 8'hC9, 8'h25, 8'h60, 8'h2F, 8'hC4, 8'h29, 8'h20, 8'h21, 8'h24,
      8'h40, 8'h41, 8'h42:         act = ACT_READ;
      8'hCA, 8'hCB, 8'h35, 8'h61, 8'h3F, 8'hC5, 8'h39, 8'h30, 8'h31, 8'h34,
      8'h3C:                       act = ACT_WRITE;
      // disabled feature sets refuse their commands
      `CMD_SMART: act = caps_ff.feat[`FEAT_SMART] ? ACT_DONE : ACT_ABORT;
      8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6:
        act = caps_ff.feat[`FEAT_SEC] ? ACT_DONE : ACT_ABORT;
      `CMD_SET_MAX, `CMD_SET_MAX48:
        act = caps_ff.feat[`FEAT_HPA] ? ACT_DONE : ACT_ABORT;
      default: act = ACT_ABORT;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start) begin
          unique case (act)
            ACT_FLUSH:  nxt_state = dirty_ff ? ST_EXEC : ST_IDLE;
            ACT_DIAG:   nxt_state = ST_EXEC;
            ACT_ID_DEV, ACT_ID_DCO: nxt_state = ST_DOUT;
            ACT_DCO_SET: nxt_state = ST_DIN;
            default:    nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_EXEC: if (cnt_ff == 8'h00) nxt_state = ST_IDLE;
      ST_DOUT: if (data_rd && idx_ff == 8'hFF) nxt_state = ST_IDLE;
      ST_DIN:  if (data_wr && idx_ff == 8'hFF) nxt_state = ST_IDLE;
    endcase
    if (soft_rst) nxt_state = ST_IDLE;
  end

  // busy stays up for the whole media write; soft reset abandons it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= nxt_state == ST_EXEC;
    end
  end

  // cycle counter for flush and diagnostics
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 8'h00;
    end else if (start && act == ACT_FLUSH) begin
      cnt_ff <= FLUSH_LD;
    end else if (start && act == ACT_DIAG) begin
      cnt_ff <= DIAG_LD;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  // 256-word data index, shared by both transfer directions
  always_ff @(posedge clk_i) begin
    if (rst_i || start || soft_rst) begin
      idx_ff <= 8'h00;
    end else if (data_rd || data_wr) begin
      idx_ff <= idx_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dco_sel_ff <= 1'b0;
    end else if (start) begin
      dco_sel_ff <= act == ACT_ID_DCO;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // completion status, result count and error register
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      err_ff    <= 1'b0;
      errreg_ff <= 8'h00;
      result_ff <= 8'h00;
      natmax_ff <= '0;
    end else if (start) begin
      err_ff    <= act == ACT_ABORT;
      errreg_ff <= (act == ACT_ABORT) ? `ERR_ABORT : 8'h00;
      if (act == ACT_DIAG) errreg_ff <= `DIAG_PASS;
      if (act == ACT_NATMAX) natmax_ff <= caps_ff.max_lba;
      if (act == ACT_CHK_PWR) begin
        unique case (pwr_ff)
          PWR_STANDBY: result_ff <= `PWR_RES_STBY;
          PWR_IDLE:    result_ff <= `PWR_RES_IDLE;
          PWR_ACTIVE:  result_ff <= `PWR_RES_ACT;
        endcase
      end
    end
  end

  // power mode follows the last power, read, cached write or flush command; forced-unit-access writes leave it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ff <= PWR_ACTIVE;
    end else if (start) begin
      unique case (act)
        ACT_STBY: pwr_ff <= PWR_STANDBY;
        ACT_IDLE: pwr_ff <= PWR_IDLE;
        ACT_READ, ACT_WRITE, ACT_FLUSH: pwr_ff <= PWR_ACTIVE;
        default: pwr_ff <= pwr_ff;
      endcase
    end
  end

  // cached write data marker; forced-unit-access writes bypass the cache
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dirty_ff <= 1'b0;
    end else if (start && act == ACT_WRITE) begin
      dirty_ff <= 1'b1;
    end else if (state_ff == ST_EXEC && cnt_ff == 8'h00 && !soft_rst) begin
      dirty_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // overlay set data capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_mdma_ff <= '0;
      set_udma_ff <= '0;
      set_feat_ff <= '0;
      set_max_ff  <= '0;
    end else if (data_wr) begin
      unique case (idx_ff)
        8'h01: set_mdma_ff <= dat_i[2:0];
        8'h02: set_udma_ff <= dat_i[6:0];
        8'h03: set_max_ff[15:0]  <= dat_i[15:0];
        8'h04: set_max_ff[31:16] <= dat_i[15:0];
        8'h05: set_max_ff[47:32] <= dat_i[15:0];
        8'h07: set_feat_ff <= dat_i[15:0];
        default: set_mdma_ff <= set_mdma_ff;
      endcase
    end
  end

  // capabilities: reduce only, changeable bits only, factory on power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      caps_ff <= '{mdma: 3'h7, udma: 7'h7F, feat: `FEAT_FACTORY,
                   max_lba: MAX_LBA_FAC};
    end else if (start && act == ACT_RESTORE) begin
      caps_ff <= '{mdma: 3'h7, udma: 7'h7F, feat: `FEAT_FACTORY,
                   max_lba: MAX_LBA_FAC};
    end else if (apply) begin
      caps_ff.mdma <= caps_ff.mdma & set_mdma_ff;
      caps_ff.udma <= caps_ff.udma & set_udma_ff;
      caps_ff.feat <= caps_ff.feat & (set_feat_ff | ~CHG_FEAT);
      if (set_max_ff != '0 && set_max_ff < caps_ff.max_lba) begin
        caps_ff.max_lba <= set_max_ff;
      end
    end
  end

  // freeze lock survives soft reset, cleared only by power-on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frozen_ff <= 1'b0;
    end else if (start && act == ACT_FREEZE) begin
      frozen_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // identify and overlay word source
  ident_word_gen u_words (
    .idx_i      (idx_ff),
    .overlay_i  (dco_sel_ff),
    .cur_i      (caps_ff),
    .fact_max_i (MAX_LBA_FAC),
    .word_o     (id_word)
  );

  // read mux, unmapped addresses read zero
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    unique case (adr_i)
      `ADR_TF0:    nxt_rdat = {tf_ff.devhead, tf_ff.sector, result_ff, tf_ff.feature};
      `ADR_TF1:    nxt_rdat = {16'h0000, tf_ff.track};
      `ADR_STAT:   nxt_rdat = {16'h0000, errreg_ff, 4'h0, frozen_ff,
                               state_ff inside {ST_DOUT, ST_DIN}, err_ff, busy_ff};
      `ADR_DATA:   nxt_rdat = (state_ff == ST_DOUT) ? {16'h0000, id_word} : 32'h0;
      `ADR_LBA_LO: nxt_rdat = natmax_ff[31:0];
      `ADR_LBA_HI: nxt_rdat = {16'h0000, natmax_ff[47:32]};
      default:     nxt_rdat = 32'h0000_0000;
    endcase
  end

  // single-wait-state slave: ack the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= wb_req;
      if (rd) rdat_ff <= nxt_rdat;
    end
  end

  assign dat_o  = rdat_ff;
  assign ack_o  = ack_ff;
  assign busy_o = busy_ff;

  //////////////////////////////////////////////////////////////////////
  // checks
  a_pwr_standby: assert property (@(posedge clk_i) disable iff (rst_i)
    start && act == ACT_CHK_PWR && pwr_ff == PWR_STANDBY |=> result_ff == 8'h00)
    else $error("power query in standby not 00h");
  a_frozen_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    start && frozen_ff && code == 8'hB1 && tf_ff.feature == 8'hC3
    |=> err_ff && errreg_ff == 8'h04 && state_ff == ST_IDLE)
    else $error("overlay set ran while frozen");
  a_frozen_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    frozen_ff |=> frozen_ff)
    else $error("frozen state left without power-on reset");
  a_flush_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    start && act == ACT_FLUSH && dirty_ff && !soft_rst
    |=> busy_o [*8] ##[1:FL_BOUND] !busy_o && !dirty_ff)
    else $error("flush busy window wrong");
  a_dco_rev: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_DOUT && dco_sel_ff && idx_ff == 8'h00 |-> id_word == 16'h0002)
    else $error("overlay revision word wrong");
  a_fixed_feat: assert property (@(posedge clk_i) disable iff (rst_i)
    apply |=> (caps_ff.feat & ~CHG_FEAT) == ($past(caps_ff.feat) & ~CHG_FEAT))
    else $error("unchangeable feature altered");
  a_natmax_val: assert property (@(posedge clk_i) disable iff (rst_i)
    start && act == ACT_NATMAX |=> natmax_ff == caps_ff.max_lba)
    else $error("native max does not follow capacity");
  a_bad_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    start && code == 8'hFF |=> err_ff && errreg_ff == 8'h04 && !busy_o)
    else $error("unknown code not aborted");
  a_unit_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_go && tf_ff.devhead[4] != UNIT_NUM |=> state_ff == ST_IDLE && !busy_o)
    else $error("command for other unit executed");
  a_diag_code: assert property (@(posedge clk_i) disable iff (rst_i)
    start && act == ACT_DIAG && !soft_rst
    |=> busy_o && errreg_ff == 8'h01 ##[1:DG_BOUND] !busy_o)
    else $error("diagnostic result wrong");
  c_flush: cover property (@(posedge clk_i) disable iff (rst_i)
    start && act == ACT_FLUSH && dirty_ff);
  c_freeze: cover property (@(posedge clk_i) disable iff (rst_i)
    start && act == ACT_FREEZE);
  c_set_done: cover property (@(posedge clk_i) disable iff (rst_i) apply);
  c_id_done: cover property (@(posedge clk_i) disable iff (rst_i)
    data_rd && idx_ff == 8'hFF);
endmodule // ata_command_decoder
`default_nettype wire

// File: tb/wb_host.sv
// host-side model: issues classic single wishbone cycles to the decoder
`default_nettype none
module wb_host (
  input  wire logic        clk_i, // core clock
  input  wire logic        ack_i, // slave ack
  input  wire logic [31:0] dat_i, // read data
  output logic             cyc_o, // cycle
  output logic             stb_o, // strobe
  output logic             we_o,  // write enable
  output logic      [7:0]  adr_o, // byte address
  output logic      [3:0]  sel_o, // byte lanes
  output logic      [31:0] dat_o  // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // request held until ack is sampled; no latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    sel_o <= 4'h0;
  endtask
endmodule // wb_host
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the storage command decoder
`default_nettype none
`include "ata_cmd_cfg.svh"
module tb_top;
  import ata_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] MAXL = 48'h0000_00EF_FFFF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] blk [256];
  logic [7:0] sum;
  int num_errors = 0;
  int num_checks = 0;
  always #5 clk_i = ~clk_i;
  ata_command_decoder #(.UNIT_NUM(1'b0), .MAX_LBA_FAC(MAXL)) u_ata_command_decoder (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .busy_o(busy));
  wb_host u_wb_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_wb_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_wb_host.xfer(1'b0, a, 32'h0, q);
  endtask
  // head bits set on purpose: they must not matter, unit bit stays 0
  task automatic cmd(input logic [7:0] f, input logic [7:0] c);
    wr(`ADR_TF0, {8'h0F, 8'h5A, 8'h3C, f});
    wr(`ADR_CMD, {24'h0, c});
  endtask
  task automatic read_blk(input logic [7:0] f, input logic [7:0] c);
    cmd(f, c);
    sum = 8'h00;
    for (int i = 0; i < 256; i++) begin
      rd(`ADR_DATA);
      blk[i] = q[15:0];
      sum = sum + q[7:0] + q[15:8];
    end
  endtask
  task automatic pwr(input logic [7:0] c, input logic [7:0] e);
    cmd(8'h00, c);
    cmd(8'h00, `CMD_CHK_PWR);
    rd(`ADR_TF0);
    chk({24'h0, q[15:8]}, {24'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power;
    pwr(8'hE0, 8'h00);
    pwr(8'hE1, 8'h80);
    pwr(`CMD_FLUSH, 8'hFF);
  endtask
  task automatic t_ident;
    read_blk(8'h00, `CMD_IDENT);
    chk({16'h0, blk[0]}, 32'h0040);
    read_blk(`SUB_IDENT, `CMD_OVERLAY);
    chk({16'h0, blk[0]}, 32'h0002);
    chk({blk[1], blk[2]}, 32'h0007_007F);
    chk({16'h0, blk[7]}, 32'h0089);
    chk({16'h0, sum, blk[255][7:0]}, {24'h0, `DCO_SIG});
  endtask
  // bad subcode and unmapped address; diag busy then result
  task automatic t_abort_diag;
    cmd(8'hC5, `CMD_OVERLAY);
    rd(`ADR_STAT);
    chk({16'h0, q[15:8], 7'h0, q[1]}, 32'h0401);
    rd(8'h20);
    chk(q, 32'h0);
    // unknown code aborts; a command for the other unit leaves status alone
    cmd(8'h00, 8'hFF);
    wr(`ADR_TF0, {8'h10, 24'h0});
    wr(`ADR_CMD, {24'h0, `CMD_DIAG});
    rd(`ADR_STAT);
    chk({16'h0, q[15:8], 6'h0, q[1:0]}, 32'h0402);
    cmd(8'h00, `CMD_DIAG);
    rd(`ADR_STAT);
    chk({31'h0, q[0]}, 32'h1);
    for (int i = 0; i < 300 && q[0] !== 1'b0; i++) rd(`ADR_STAT);
    chk({16'h0, q[15:8], 7'h0, q[0]}, 32'h0100);
    cmd(8'h00, `CMD_NATMAX);
    rd(`ADR_LBA_LO);
    chk(q, MAXL[31:0]);
  endtask
  // freeze survives soft reset, not power-on reset
  task automatic t_freeze;
    cmd(`SUB_FREEZE, `CMD_OVERLAY);
    cmd(`SUB_IDENT, `CMD_OVERLAY);
    cmd(`SUB_SET, `CMD_OVERLAY);
    rd(`ADR_STAT);
    chk({16'h0, q[15:8], 4'h0, q[3:0]}, 32'h040A);
    wr(`ADR_CTRL, 32'h1);
    rd(`ADR_STAT);
    chk({31'h0, q[3]}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ADR_STAT);
    chk({31'h0, q[3]}, 32'h0);
  endtask
  // a cached write makes the flush hold busy; a forced-unit-access write does not
  task automatic t_flush;
    int n = 0;
    cmd(8'h00, 8'hCA);
    cmd(8'h00, `CMD_FLUSH_EXT);
    chk({31'h0, busy}, 32'h1);
    while (busy === 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(n, `FLUSH_CYC);
    cmd(8'h00, `CMD_WR_DMA_FUA);
    cmd(8'h00, `CMD_FLUSH);
    rd(`ADR_STAT);
    chk({30'h0, q[1:0]}, 32'h0);
    chk({31'h0, busy}, 32'h0);
  endtask
  // overlay set lowers modes, features and capacity; restore brings factory back
  task automatic t_set;
    cmd(`SUB_SET, `CMD_OVERLAY);
    for (int i = 0; i < 256; i++) begin
      wr(`ADR_DATA, (i == 1) ? 32'hFFF3 : (i == 2) ? 32'h001F :
                    (i == 3) ? 32'h1234 : (i == 7) ? 32'hFF76 : 32'h0);
    end
    read_blk(8'h00, `CMD_IDENT);
    chk({blk[63], blk[88]}, 32'h0003_001F);
    chk({16'h0, blk[82]}, 32'h0);
    chk({blk[61], blk[60]}, 32'h1234);
    chk({blk[101], blk[100]}, 32'h1234);
    read_blk(`SUB_IDENT, `CMD_OVERLAY);
    chk({blk[1], blk[2]}, 32'h0007_007F);
    chk({24'h0, sum}, 32'h0);
    cmd(8'h00, `CMD_SMART);
    rd(`ADR_STAT);
    chk({24'h0, q[15:8]}, 32'h04);
    cmd(8'h00, `CMD_NATMAX48);
    rd(`ADR_LBA_LO);
    chk(q, 32'h1234);
    cmd(`SUB_RESTORE, `CMD_OVERLAY);
    read_blk(8'h00, `CMD_IDENT);
    chk({blk[63], blk[88]}, 32'h0007_007F);
    cmd(8'h00, `CMD_NATMAX);
    rd(`ADR_LBA_LO);
    chk(q, MAXL[31:0]);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power();
    t_flush();
    t_ident();
    t_abort_diag();
    t_set();
    t_freeze();
    wrap_up();
  end
  // watchdog: run needs a few thousand cycles
  initial begin
    repeat (50000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
